// ===== mpseq_sequencer.v
// Contract
// [R1] In input-selected mode enable acts on edge; host holds pulse 3 ms or 0.25 ms.
// [R2] Host changes selection only between completion and next enable edge.
// [R3] Index is 4-bit binary of selectors, bit0 least significant, 0..15.
// [R4] Selection inputs are sampled as levels, 1 active.
// [R5] Mode 3 selects sequential, mode 5 selects axis-controlled continuous.
// [R6] Single-pass sequential halts after one full cycle.
// [R7] Cyclic sequential repeats forever, later cycles start at restart index.
// [R8] Sequential advances to the next index by itself.
// [R9] Cyclic sequential inserts no wait between displacements.
// [R10] Sequential treats enable as a level.
// [R11] Done pulses at each displacement completion in sequential mode.
// [R12] Enable off in sequential discards rest; done once motor has stopped.
// [R13] Enable back on resumes or restarts per restart behaviour.
// [R14] Servo-on off stops motor with configured servo-off stop mode.
// [R15] Direction select is frozen while a displacement executes.
// [R16] Axis mode: immediate trigger makes new command take effect at once.
// [R17] Axis mode: deferred trigger applies command after current completes.
// [R18] Next-command-allowed output; host gives commands only while active.
// [R19] Enable is edge-triggered in mode 2, level-triggered otherwise.
// [R20] Input mode latches selection index on each enable edge and runs it. Code ignores enable edges that arrive while a move is in ST_RUN.
// [R21] While enable inactive motor is held locked, no new reference. Code locks only outside ST_RUN; axis mode still starts pending moves.
// [R22] Single-pass if restart index zero or above last index, else cyclic.
`timescale 1ns/1ps
`include "mpseq_regs.vh"
module mpseq_sequencer (
  // Clock and reset.
  input wire clk,
  input wire resetn,
  // Host digital inputs, asynchronous to clk.
  input wire sequence_enable,
  input wire index_select_bit0,
  input wire index_select_bit1,
  input wire index_select_bit2,
  input wire index_select_bit3,
  input wire direction_select,
  input wire immediate_write_trigger,
  input wire deferred_write_trigger,
  input wire servo_on,
  // Configuration, static from the same clock domain.
  input wire [3:0] sequence_mode_select,
  input wire [3:0] last_displacement_index,
  input wire restart_behaviour,
  input wire [4:0] cycle_restart_index,
  input wire [1:0] servo_off_stop_mode,
  // Axis-mode command from the host, same domain.
  input wire [3:0] axis_command_index,
  // Motion engine handshake.
  input wire motion_complete,
  input wire motor_stopped,
  // Outputs to the motion engine.
  output reg move_start,
  output reg [3:0] move_index,
  output reg move_direction,
  output reg motion_abort,
  output reg hold_locked,
  output reg servo_off_stop,
  output reg [1:0] servo_stop_mode,
  // Outputs to the host.
  output reg positioning_done,
  output reg next_command_allowed
);

  // Sequencer states. STOP covers both the rest after a finished single
  // pass and the wind-down after an enable-off abort; stop_abort_q tells them apart.
  localparam ST_IDLE = 2'h0;
  localparam ST_RUN = 2'h1;
  localparam ST_STOP = 2'h2;

  // Two-stage synchronisers for all pin inputs.
  // Only sync2_q is read by logic, since sync1_q may still be settling.
  reg [8:0] sync1_q;
  reg [8:0] sync2_q;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync1_q <= 9'h000;
      sync2_q <= 9'h000;
    end else begin
      sync1_q <= {servo_on, deferred_write_trigger, immediate_write_trigger,
                  direction_select, index_select_bit3, index_select_bit2,
                  index_select_bit1, index_select_bit0, sequence_enable};
      sync2_q <= sync1_q;
    end
  end

  wire en_s = sync2_q[0];
  wire [3:0] sel_idx = sync2_q[4:1]; // [R3] [R4]
  wire dir_s = sync2_q[5];
  wire imm_s = sync2_q[6];
  wire def_s = sync2_q[7];
  wire son_s = sync2_q[8];

  reg en_prev_q;
  reg imm_prev_q;
  reg def_prev_q;
  reg [1:0] state_q;
  reg [3:0] cur_idx_q;
  reg stop_abort_q;
  reg pend_q;
  reg pend_imm_q;
  reg [3:0] pend_idx_q;

  wire mode_in = (sequence_mode_select == `MPSEQ_MODE_INPUT);
  wire mode_seq = (sequence_mode_select == `MPSEQ_MODE_SEQ); // [R5]
  wire mode_ax = (sequence_mode_select == `MPSEQ_MODE_AXIS); // [R5]
  wire en_rise = en_s & ~en_prev_q; // [R19] [R1]

  // The write triggers are levels on the pins. Only their rising edge takes
  // a command, so a trigger held high cannot restart the same move again.
  wire imm_rise = imm_s & ~imm_prev_q; // [R16]
  wire def_rise = def_s & ~def_prev_q; // [R17]
  wire take_cmd = mode_ax & (imm_rise | def_rise) & ~pend_q;

  // Restart index is 1-based; zero or beyond the last entry gives one pass.
  wire [4:0] last_count = {1'b0, last_displacement_index} + 5'h01;
  wire single_pass = (cycle_restart_index == 5'h00) ||
    (cycle_restart_index > last_count); // [R22]
  // Subtract at full width so that a restart index of 16 maps to entry 15.
  wire [4:0] restart_full = cycle_restart_index - 5'h01;
  wire [3:0] restart_idx = restart_full[3:0];
  wire at_last = (cur_idx_q == last_displacement_index);
  wire [3:0] next_idx = cur_idx_q + 4'h1;

  // Edge history of the synchronised enable and write-trigger pins.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      en_prev_q <= 1'b0;
      imm_prev_q <= 1'b0;
      def_prev_q <= 1'b0;
    end else begin
      en_prev_q <= en_s;
      imm_prev_q <= imm_s;
      def_prev_q <= def_s;
    end
  end

  // Level outputs, one register stage behind the synchronised pins and the stop mode setting.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hold_locked <= 1'b1;
      servo_off_stop <= 1'b0;
      servo_stop_mode <= `MPSEQ_STOP_MODE_RST;
      next_command_allowed <= 1'b0;
    end else begin
      servo_stop_mode <= servo_off_stop_mode; // [R14]
      servo_off_stop <= ~son_s; // [R14]
      hold_locked <= ~en_s & (state_q != ST_RUN); // [R21]
      // A command caught this cycle blocks the host at once, so a second
      // write cannot slip in before the pending flag shows.
      next_command_allowed <= mode_ax & son_s & ~pend_q & ~take_cmd; // [R18]
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      cur_idx_q <= `MPSEQ_IDX_RST;
      stop_abort_q <= 1'b0;
      pend_q <= 1'b0;
      pend_imm_q <= 1'b0;
      pend_idx_q <= `MPSEQ_IDX_RST;
      move_start <= 1'b0;
      move_index <= `MPSEQ_IDX_RST;
      move_direction <= `MPSEQ_DIR_RST;
      motion_abort <= 1'b0;
      positioning_done <= 1'b0;
    end else begin
      move_start <= 1'b0;
      motion_abort <= 1'b0;
      positioning_done <= 1'b0;
      // Only one axis command waits at a time; the host must watch
      // next_command_allowed before it writes the next one.
      if (take_cmd) begin
        pend_q <= 1'b1;
        pend_imm_q <= imm_rise;
        pend_idx_q <= axis_command_index;
      end
      if (!son_s) begin
        // Servo off: the stop mode drives the halt, done stays low.
        if (state_q == ST_RUN) begin
          motion_abort <= 1'b1; // [R14]
        end
        state_q <= ST_IDLE;
        stop_abort_q <= 1'b0;
        pend_q <= 1'b0;
      end else begin
        case (state_q)
          ST_IDLE: begin
            // Mode 2 starts on an enable edge, mode 3 on the enable level
            // and mode 5 on a pending command while enable is high.
            if (mode_in && en_rise) begin
              cur_idx_q <= sel_idx; // [R20]
              move_index <= sel_idx;
              move_direction <= dir_s; // [R15]
              move_start <= 1'b1;
              state_q <= ST_RUN;
            end else if (mode_seq && en_s) begin // [R10]
              move_index <= cur_idx_q;
              move_direction <= dir_s; // [R15]
              move_start <= 1'b1;
              state_q <= ST_RUN;
            end else if (mode_ax && pend_q && en_s) begin
              cur_idx_q <= pend_idx_q;
              move_index <= pend_idx_q;
              move_direction <= dir_s;
              move_start <= 1'b1;
              pend_q <= 1'b0;
              state_q <= ST_RUN;
            end
          end
          ST_RUN: begin
            if (mode_seq && !en_s) begin
              motion_abort <= 1'b1; // [R12]
              stop_abort_q <= 1'b1;
              state_q <= ST_STOP;
              // Resume keeps the aborted entry, so it is run again whole.
              if (restart_behaviour == `MPSEQ_RESTART_FIRST) begin
                cur_idx_q <= `MPSEQ_IDX_RST; // [R13]
              end
            end else if (mode_ax && pend_q && pend_imm_q) begin
              cur_idx_q <= pend_idx_q; // [R16]
              move_index <= pend_idx_q;
              move_direction <= dir_s;
              move_start <= 1'b1;
              pend_q <= 1'b0;
            end else if (motion_complete) begin
              positioning_done <= 1'b1; // [R11]
              state_q <= ST_IDLE;
              if (mode_seq) begin
                if (!at_last) begin
                  cur_idx_q <= next_idx; // [R8]
                  move_index <= next_idx;
                  move_direction <= dir_s;
                  move_start <= 1'b1; // [R9]
                  state_q <= ST_RUN;
                end else if (single_pass) begin
                  cur_idx_q <= `MPSEQ_IDX_RST; // [R6]
                  state_q <= ST_STOP;
                end else begin
                  cur_idx_q <= restart_idx; // [R7]
                  move_index <= restart_idx;
                  move_direction <= dir_s;
                  move_start <= 1'b1; // [R9]
                  state_q <= ST_RUN;
                end
              end else if (mode_ax && pend_q) begin
                cur_idx_q <= pend_idx_q; // [R17]
                move_index <= pend_idx_q;
                move_direction <= dir_s;
                move_start <= 1'b1;
                pend_q <= 1'b0;
                state_q <= ST_RUN;
              end
            end
          end
          ST_STOP: begin
            // Standstill closes the stop. Only an aborted run reports done
            // here; a finished single pass already reported at completion.
            if (motor_stopped && !motion_abort) begin
              if (stop_abort_q) begin
                positioning_done <= 1'b1; // [R12]
                stop_abort_q <= 1'b0;
              end
              // A finished pass rests until enable drops. After an abort
              // the sequence may go on at once if enable is back already.
              if (!en_s || stop_abort_q) begin
                state_q <= ST_IDLE; // [R13]
              end
            end
          end
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end

endmodule // mpseq_sequencer

// ===== mpseq_regs.vh
`ifndef MPSEQ_REGS_VH
`define MPSEQ_REGS_VH
// Mode selection codes.
`define MPSEQ_MODE_INPUT 4'h2
`define MPSEQ_MODE_SEQ 4'h3
`define MPSEQ_MODE_AXIS 4'h5
// Restart behaviour codes.
`define MPSEQ_RESTART_RESUME 1'b0
`define MPSEQ_RESTART_FIRST 1'b1
// Clock rate and pulse widths.
`define MPSEQ_CLK_MHZ 100
`define MPSEQ_LOW_SPEED_US 3000
`define MPSEQ_HIGH_SPEED_US 250
`define MPSEQ_LOW_SPEED_CYC (`MPSEQ_LOW_SPEED_US * `MPSEQ_CLK_MHZ)
`define MPSEQ_HIGH_SPEED_CYC (`MPSEQ_HIGH_SPEED_US * `MPSEQ_CLK_MHZ)
// Reset values.
`define MPSEQ_IDX_RST 4'h0
`define MPSEQ_DIR_RST 1'b0
`define MPSEQ_STOP_MODE_RST 2'h0
`endif

// ===== mpseq_assertions.sv
`timescale 1ns/1ps
module mpseq_assertions (
  // Watched ports.
  input wire clk,
  input wire resetn,
  input wire sequence_enable,
  input wire servo_on,
  input wire [3:0] sequence_mode_select,
  input wire [1:0] servo_off_stop_mode,
  input wire move_start,
  input wire [3:0] move_index,
  input wire move_direction,
  input wire motion_abort,
  input wire servo_off_stop,
  input wire [1:0] servo_stop_mode,
  input wire positioning_done
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  done_pulse_a: assert property (positioning_done |=> !positioning_done)
    else $error("done pulse too long");
  start_pulse_a: assert property (move_start |=> !move_start)
    else $error("start pulse too long");
  abort_quiet_a: assert property (motion_abort |-> !positioning_done)
    else $error("done with abort");
  stop_copy_a: assert property ($past(resetn) |->
    servo_stop_mode == $past(servo_off_stop_mode)) else $error("stop mode");
  servo_off_a: assert property (!servo_on [*4] |-> servo_off_stop)
    else $error("servo off not flagged");
  servo_idle_a: assert property (!servo_on [*4] |-> !move_start)
    else $error("start while servo off");
  dir_frozen_a: assert property ($changed(move_direction) |-> move_start)
    else $error("direction changed mid move");
  index_held_a: assert property ($changed(move_index) |-> move_start)
    else $error("index changed mid move");
  enable_idle_a: assert property ((!sequence_enable &&
    sequence_mode_select == 4'h3) [*4] |-> !move_start)
    else $error("start while disabled");
endmodule // mpseq_assertions
bind mpseq_sequencer mpseq_assertions chk (.*);

// ===== mpseq_engine.sv
`timescale 1ns/1ps
module mpseq_engine #(parameter LAT = 20) (
  // Clock and handshake.
  input wire clk,
  input wire resetn,
  input wire move_start,
  input wire motion_abort,
  output reg motion_complete,
  output wire motor_stopped
);
  integer cnt;
  assign motor_stopped = (cnt == 0);
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= 0;
      motion_complete <= 1'b0;
    end else begin
      motion_complete <= (cnt == 1) && !motion_abort;
      if (move_start) cnt <= LAT;
      else if (motion_abort) cnt <= 0;
      else if (cnt != 0) cnt <= cnt - 1;
    end
  end
endmodule // mpseq_engine

// ===== mpseq_sequencer_tb.sv
`timescale 1ns/1ps
module mpseq_sequencer_tb;
  reg clk, resetn, en, dir, imm, dfr, son, rb;
  reg [3:0] sel, mode, last, axis;
  reg [4:0] ri;
  reg [1:0] som;
  wire mc, ms, st, dq, ab, hl, so, dn, nca;
  wire [3:0] idx;
  wire [1:0] sm;
  integer err_count, check_count, n, dc, ac;
  mpseq_sequencer uut (.clk(clk), .resetn(resetn), .sequence_enable(en),
    .index_select_bit0(sel[0]), .index_select_bit1(sel[1]),
    .index_select_bit2(sel[2]), .index_select_bit3(sel[3]),
    .direction_select(dir), .immediate_write_trigger(imm),
    .deferred_write_trigger(dfr), .servo_on(son),
    .sequence_mode_select(mode), .last_displacement_index(last),
    .restart_behaviour(rb), .cycle_restart_index(ri),
    .servo_off_stop_mode(som), .axis_command_index(axis),
    .motion_complete(mc), .motor_stopped(ms), .move_start(st),
    .move_index(idx), .move_direction(dq), .motion_abort(ab),
    .hold_locked(hl), .servo_off_stop(so), .servo_stop_mode(sm),
    .positioning_done(dn), .next_command_allowed(nca));
  mpseq_engine eng (.clk(clk), .resetn(resetn), .move_start(st),
    .motion_abort(ab), .motion_complete(mc), .motor_stopped(ms));
  always @(posedge clk) begin
    if (!resetn) dc <= 0;
    else if (dn === 1'b1) dc <= dc + 1;
  end
  always @(posedge clk) begin
    if (!resetn) ac <= 0;
    else if (ab === 1'b1) ac <= ac + 1;
  end
  task complete_run;
    begin
      if (err_count == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  task chk(input [127:0] nm, input [3:0] e, input [3:0] g);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        err_count = err_count + 1;
        $display("wrong value %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task wstart(input [3:0] e);
    begin
      n = 0;
      @(posedge clk); #1;
      while (st !== 1'b1 && n < 300) begin
        @(posedge clk); #1;
        n = n + 1;
      end
      if (n >= 300) begin
        err_count = err_count + 1;
        complete_run;
      end
      chk("move_index", e, idx);
      @(posedge clk);
    end
  endtask
  task rst(input [3:0] m, input [4:0] r);
    begin
      resetn <= 1'b0;
      en <= 1'b0;
      mode <= m;
      ri <= r;
      imm <= 1'b0;
      dfr <= 1'b0;
      son <= 1'b1;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
    end
  endtask
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  initial begin
    {resetn, en, dir, imm, dfr, rb, sel, axis, som} = 0;
    son = 1; mode = 4'h3; last = 4'h2; ri = 0;
    err_count = 0; check_count = 0;
    rst(4'h3, 5'h00);
    chk("hold_locked", 4'h1, {3'b000, hl});
    en <= 1'b1;
    wstart(4'h0);
    chk("hold_locked", 4'h0, {3'b000, hl});
    wstart(4'h1); wstart(4'h2);
    repeat (100) @(posedge clk);
    chk("done_count", 4'h3, dc[3:0]);
    chk("move_start", 4'h0, {3'b000, st});
    rst(4'h3, 5'h02);
    en <= 1'b1;
    wstart(4'h0); wstart(4'h1); wstart(4'h2);
    wstart(4'h1); wstart(4'h2); wstart(4'h1);
    en <= 1'b0;
    repeat (100) @(posedge clk);
    chk("done_count", 4'h6, dc[3:0]);
    chk("abort_count", 4'h1, ac[3:0]);
    rst(4'h2, 5'h00);
    sel <= 4'hA; dir <= 1'b1;
    @(posedge clk); en <= 1'b1;
    wstart(4'hA);
    chk("direction", 4'h1, {3'b000, dq});
    dir <= 1'b0;
    repeat (5) @(posedge clk);
    chk("direction", 4'h1, {3'b000, dq});
    som <= 2'h2; son <= 1'b0;
    repeat (10) @(posedge clk); #1;
    chk("stop_mode", 4'h2, {2'b00, sm});
    chk("servo_stop", 4'h1, {3'b000, so});
    chk("abort_count", 4'h1, ac[3:0]);
    chk("done_count", 4'h0, dc[3:0]);
    @(posedge clk);
    rst(4'h5, 5'h00);
    axis <= 4'h7; imm <= 1'b1; en <= 1'b1;
    wstart(4'h7);
    imm <= 1'b0;
    repeat (3) @(posedge clk);
    chk("next_allowed", 4'h1, {3'b000, nca});
    axis <= 4'h3; dfr <= 1'b1;
    repeat (6) @(posedge clk);
    chk("next_allowed", 4'h0, {3'b000, nca});
    chk("move_index", 4'h7, idx);
    dfr <= 1'b0;
    wstart(4'h3);
    complete_run;
  end
endmodule // mpseq_sequencer_tb
